// ### core/slave_id_registers.sv
`timescale 1ns/1ps
`include "slave_id_defs.svh"
module slave_id_registers (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire slave_id_pkg::reg_write_t wrReq,
  input  wire slave_id_pkg::reg_read_t  rdReq,
  input  wire logic [1:0]              powerModeField,
  input  wire logic                    softResetBit,
  output logic [3:0]                   slaveId,
  output logic [7:0]                   rdData,
  output logic                         rdValid,
  output logic                         rdMiss,
  output logic                         idWriteRejected
);

  // write aimed at the identifier register
  function automatic logic is_id_write(
    input slave_id_pkg::reg_write_t req
  );
    logic hit;
    hit = 1'b0;
    if (req.valid) begin
      hit = (req.regAddr == `ADDR_SLAVE_ID);
    end
    return hit;
  endfunction : is_id_write

  // broadcast slave address
  function automatic logic is_broadcast(
    input logic [3:0] addr
  );
    logic hit;
    hit = 1'b0;
    if (addr == `BROADCAST_ADDR) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : is_broadcast

  // slave address equal to the held identifier
  function automatic logic is_own(
    input logic [3:0] addr,
    input logic [3:0] held
  );
    logic hit;
    hit = 1'b0;
    if (addr == held) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : is_own

  // upper nibble must carry the fixed pattern
  function automatic logic pattern_matches(
    input logic [3:0] upper
  );
    logic hit;
    hit = 1'b0;
    if (upper == `UPPER_PATTERN) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : pattern_matches

  function automatic logic is_shutdown(
    input logic [1:0] mode
  );
    logic hit;
    hit = 1'b0;
    case (mode)
      `PM_SHUTDOWN: hit = 1'b1;
      default:      hit = 1'b0;
    endcase
    return hit;
  endfunction : is_shutdown

  // startup code seen now but not on the previous cycle
  function automatic logic enters_startup(
    input logic [1:0] mode,
    input logic [1:0] prev
  );
    logic hit;
    hit = 1'b0;
    if (mode == `PM_STARTUP) begin
      hit = (prev != `PM_STARTUP);
    end
    return hit;
  endfunction : enters_startup

  // addressed write with the right upper nibble
  function automatic logic write_accepted(
    input logic idWrite,
    input logic addressed,
    input logic patternOk
  );
    return idWrite && addressed && patternOk;
  endfunction : write_accepted

  // addressed write with a wrong upper nibble
  function automatic logic write_refused(
    input logic idWrite,
    input logic addressed,
    input logic patternOk
  );
    return idWrite && addressed && !patternOk;
  endfunction : write_refused

  // read image: reserved, manufacturer bits, identifier
  function automatic logic [7:0] id_word(
    input logic [3:0] held
  );
    logic [7:0] word;
    word      = 8'h00;
    word[7:6] = `ID_RESERVED_BITS;
    word[5:4] = `ID_MANUF_BITS;
    word[3:0] = held;
    return word;
  endfunction : id_word

  // registered state
  logic [3:0] slaveId_r;
  logic [3:0] slaveId_nxt;
  logic [1:0] powerMode_r;
  logic [1:0] powerMode_nxt;
  logic       rejected_r;
  logic       rejected_nxt;

  // decoded request and power mode
  logic       idWrite;
  logic       broadcastHit;
  logic       ownHit;
  logic       addressed;
  logic       patternOk;
  logic       acceptWrite;
  logic       refuseWrite;
  logic       shutdownNow;
  logic       startupEntry;

  // read image
  logic [7:0] slaveIdWord;

  // request decode, shared by the identifier and reject groups, plus power-mode decode for the identifier
  always_comb begin
    idWrite      = is_id_write(wrReq);
    broadcastHit = is_broadcast(wrReq.slaveAddr);
    ownHit       = is_own(wrReq.slaveAddr, slaveId_r);
    addressed    = broadcastHit || ownHit;
    patternOk    = pattern_matches(wrReq.data[7:4]);
    acceptWrite  = write_accepted(idWrite, addressed, patternOk);
    refuseWrite  = write_refused(idWrite, addressed, patternOk);
    shutdownNow  = is_shutdown(powerModeField);
    startupEntry = enters_startup(powerModeField, powerMode_r);
  end

  // previous power mode, for spotting entry into startup
  always_comb begin
    powerMode_nxt = powerModeField;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      powerMode_r <= `PM_ACTIVE;
    end else begin
      powerMode_r <= powerMode_nxt;
    end
  end

  // shutdown and startup entry win over a write in the same cycle
  always_comb begin
    slaveId_nxt = slaveId_r;
    if (acceptWrite) begin
      slaveId_nxt = wrReq.data[3:0];
    end
    if (shutdownNow) begin
      slaveId_nxt = `SLAVE_ID_RESET;
    end
    if (startupEntry) begin
      slaveId_nxt = `SLAVE_ID_RESET;
    end
  end

  // soft reset bit deliberately not read here
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slaveId_r <= `SLAVE_ID_RESET;
    end else begin
      slaveId_r <= slaveId_nxt;
    end
  end

  always_comb begin
    rejected_nxt = 1'b0;
    if (refuseWrite) begin
      rejected_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rejected_r <= 1'b0;
    end else begin
      rejected_r <= rejected_nxt;
    end
  end

  always_comb begin
    slaveIdWord = id_word(slaveId_r);
  end

  assign slaveId         = slaveId_r;
  assign idWriteRejected = rejected_r;

  slave_id_read_port readPort (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .rdReq       (rdReq),
    .slaveIdWord (slaveIdWord),
    .rdData      (rdData),
    .rdValid     (rdValid),
    .rdMiss      (rdMiss)
  );
endmodule : slave_id_registers

// ### core/slave_id_defs.svh
`ifndef SLAVE_ID_DEFS_SVH
`define SLAVE_ID_DEFS_SVH
`define ADDR_MANUF_LOW    5'h1e
`define ADDR_SLAVE_ID     5'h1f
`define BROADCAST_ADDR    4'h0
`define MANUF_LOW_VALUE   8'h5a  // value arbitrary
`define ID_RESERVED_BITS  2'h0
`define ID_MANUF_BITS     2'h2   // value arbitrary
`define UPPER_PATTERN     4'h2   // reserved and manufacturer bits together, value arbitrary
`define SLAVE_ID_RESET    4'h7
`define PM_ACTIVE         2'h0
`define PM_STARTUP        2'h1
`define PM_SHUTDOWN       2'h3
`endif

// ### core/slave_id_pkg.sv
package slave_id_pkg;
  typedef struct packed {
    logic       valid;
    logic [3:0] slaveAddr;
    logic [4:0] regAddr;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] regAddr;
  } reg_read_t;
endpackage : slave_id_pkg

// ### core/slave_id_read_port.sv
`timescale 1ns/1ps
`include "slave_id_defs.svh"
module slave_id_read_port (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire slave_id_pkg::reg_read_t rdReq,
  input  wire logic [7:0]             slaveIdWord,
  output logic [7:0]                  rdData,
  output logic                        rdValid,
  output logic                        rdMiss
);
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic       rdValid_r;
  logic       rdValid_nxt;
  logic       rdMiss_r;
  logic       rdMiss_nxt;

  always_comb begin
    rdData_nxt  = 8'h00;
    rdValid_nxt = rdReq.valid;
    rdMiss_nxt  = 1'b0;
    if (rdReq.valid) begin
      case (rdReq.regAddr)
        `ADDR_MANUF_LOW: rdData_nxt = `MANUF_LOW_VALUE;
        `ADDR_SLAVE_ID:  rdData_nxt = slaveIdWord;
        default:         rdMiss_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdData_r  <= 8'h00;
      rdValid_r <= 1'b0;
      rdMiss_r  <= 1'b0;
    end else begin
      rdData_r  <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
      rdMiss_r  <= rdMiss_nxt;
    end
  end

  assign rdData  = rdData_r;
  assign rdValid = rdValid_r;
  assign rdMiss  = rdMiss_r;
endmodule : slave_id_read_port

// ### dv/slave_id_registers_properties.sv
`timescale 1ns/1ps
`include "slave_id_defs.svh"
module slave_id_checker (
  input wire logic                     clk_sys,
  input wire logic                     reset,
  input wire slave_id_pkg::reg_write_t wrReq,
  input wire slave_id_pkg::reg_read_t  rdReq,
  input wire logic [1:0]               powerModeField,
  input wire logic                     softResetBit,
  input wire logic [3:0]               slaveId,
  input wire logic [7:0]               rdData,
  input wire logic                     rdValid,
  input wire logic                     idWriteRejected
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire       q   = powerModeField == 2'h0;
  wire       w   = wrReq.valid && wrReq.regAddr == `ADDR_SLAVE_ID && q;
  wire       ok  = wrReq.data[7:4] == `UPPER_PATTERN;
  wire       bc  = wrReq.slaveAddr == `BROADCAST_ADDR;
  wire       own = wrReq.slaveAddr == slaveId;
  wire [3:0] nid = wrReq.data[3:0];
  id_read_a: assert property (rdReq.valid && rdReq.regAddr == `ADDR_SLAVE_ID
    |=> rdValid && rdData == {`UPPER_PATTERN, $past(slaveId)}) else $error("id read");
  manuf_read_a: assert property (rdReq.valid && rdReq.regAddr == `ADDR_MANUF_LOW
    |=> rdValid && rdData == `MANUF_LOW_VALUE) else $error("manuf read");
  id_load_a: assert property (w && ok && (bc || own) |=> slaveId == $past(nid)) else $error("load");
  bad_upper_a: assert property (w && !ok && own && !bc
    |=> $stable(slaveId) && idWriteRejected) else $error("upper");
  stray_write_a: assert property (w && !bc && !own |=> $stable(slaveId)) else $error("stray");
  shutdown_id_a: assert property (powerModeField == `PM_SHUTDOWN
    |=> slaveId == `SLAVE_ID_RESET) else $error("shutdown");
  soft_reset_a: assert property (softResetBit && q && !wrReq.valid |=> $stable(slaveId)) else $error("swr");
  startup_entry_a: assert property (powerModeField == `PM_STARTUP && $past(powerModeField) != `PM_STARTUP
    |=> slaveId == `SLAVE_ID_RESET) else $error("startup");
endmodule : slave_id_checker
bind slave_id_registers slave_id_checker i_chk (.*);

// ### dv/rffe_master_model.sv
`timescale 1ns/1ps
`include "slave_id_defs.svh"
module rffe_master_model (
  input  wire logic                clk_sys,
  input  wire logic [7:0]          rdData,
  input  wire logic                rdValid,
  input  wire logic                rdMiss,
  input  wire logic                idWriteRejected,
  output slave_id_pkg::reg_write_t wrReq,
  output slave_id_pkg::reg_read_t  rdReq
);
  initial begin
    wrReq = 18'h0_0000;
    rdReq = 6'h00;
  end
  task automatic wr(input logic [3:0] sa, input logic [7:0] d, output logic rej);
    @(posedge clk_sys) #1 wrReq = {1'b1, sa, `ADDR_SLAVE_ID, d};
    @(posedge clk_sys) #1 rej = idWriteRejected;
    wrReq = {1'b0, ~wrReq[16:0]};
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic m);
    @(posedge clk_sys) #1 rdReq = {1'b1, a};
    @(posedge clk_sys) #1 d = rdValid ? rdData : 8'hxx;
    m     = rdMiss;
    rdReq = {1'b0, ~rdReq[4:0]};
  endtask : rd
endmodule : rffe_master_model

// ### dv/tb_rffe_slave_id_registers.sv
`timescale 1ns/1ps
`include "slave_id_defs.svh"
module tb_rffe_slave_id_registers;
  logic                     clk_sys, reset, softResetBit;
  logic                     rdValid, rdMiss, idWriteRejected, rej, miss;
  logic [1:0]               powerModeField;
  logic [3:0]               slaveId;
  logic [7:0]               rdData, got;
  slave_id_pkg::reg_write_t wrReq;
  slave_id_pkg::reg_read_t  rdReq;
  int                       num_errors, samples_checked;
  slave_id_registers i_dut (.clk_sys, .reset, .wrReq, .rdReq, .powerModeField, .softResetBit,
    .slaveId, .rdData, .rdValid, .rdMiss, .idWriteRejected);
  rffe_master_model i_mst (.clk_sys, .rdData, .rdValid, .rdMiss, .idWriteRejected, .wrReq, .rdReq);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic s_writes;
    i_mst.rd(`ADDR_SLAVE_ID, got, miss);
    chk("id", {`UPPER_PATTERN, `SLAVE_ID_RESET}, got);
    i_mst.rd(`ADDR_MANUF_LOW, got, miss);
    chk("manuf", `MANUF_LOW_VALUE, got);
    chk("manufMiss", 8'h00, {7'h00, miss});
    i_mst.rd(5'h1c, got, miss);
    chk("unmappedMiss", 8'h01, {7'h00, miss});
    i_mst.wr(`SLAVE_ID_RESET, {`UPPER_PATTERN, 4'h5}, rej);
    chk("own", 8'h05, {4'h0, slaveId});
    chk("ownRej", 8'h00, {7'h00, rej});
    i_mst.wr(`BROADCAST_ADDR, {`UPPER_PATTERN, 4'h9}, rej);
    chk("bcast", 8'h09, {4'h0, slaveId});
    i_mst.wr(4'h3, {`UPPER_PATTERN, 4'h2}, rej);
    chk("stray", 8'h09, {4'h0, slaveId});
    chk("strayRej", 8'h00, {7'h00, rej});
    i_mst.wr(4'h9, {~`UPPER_PATTERN, 4'h2}, rej);
    chk("upper", 8'h09, {4'h0, slaveId});
    chk("upperRej", 8'h01, {7'h00, rej});
    softResetBit = 1'b1;
    @(posedge clk_sys) #1 softResetBit = 1'b0;
    chk("swr", 8'h09, {4'h0, slaveId});
  endtask : s_writes
  task automatic s_reset;
    i_mst.wr(`BROADCAST_ADDR, {`UPPER_PATTERN, 4'hc}, rej);
    chk("preReset", 8'h0c, {4'h0, slaveId});
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    chk("reset", {4'h0, `SLAVE_ID_RESET}, {4'h0, slaveId});
  endtask : s_reset
  task automatic s_power;
    i_mst.wr(`BROADCAST_ADDR, {`UPPER_PATTERN, 4'h9}, rej);
    chk("preOff", 8'h09, {4'h0, slaveId});
    powerModeField = `PM_SHUTDOWN;
    @(posedge clk_sys) #1 powerModeField = `PM_ACTIVE;
    chk("off", {4'h0, `SLAVE_ID_RESET}, {4'h0, slaveId});
    i_mst.wr(`BROADCAST_ADDR, {`UPPER_PATTERN, 4'h6}, rej);
    chk("preStart", 8'h06, {4'h0, slaveId});
    powerModeField = `PM_STARTUP;
    @(posedge clk_sys) #1 chk("start", {4'h0, `SLAVE_ID_RESET}, {4'h0, slaveId});
  endtask : s_power
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    reset = 1'b1;
    softResetBit = 1'b0;
    powerModeField = 2'h0;
    num_errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk_sys);
    #1 reset = 1'b0;
    s_writes;
    s_reset;
    s_power;
    conclude;
  end
endmodule : tb_rffe_slave_id_registers
